//--- design/srr_fullstep_div.sv
// Divides microstep pulses by 2^resolution into full-step pulses
`timescale 1ns/100ps
`default_nettype none

module srr_fullstep_div
  import srr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Microstep side
  input  wire logic       ustep_pulse,
  input  wire logic [3:0] ures,
  // Full-step side
  output logic            full_pulse
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       full;
  } srr_div_state_t;

  srr_div_state_t r;
  srr_div_state_t next_r;
  logic [8:0]     mask;

  always_comb begin
    next_r = r;
    next_r.full = 1'b0;
    mask = (9'h001 << ures) - 9'h001;
    if (ustep_pulse) begin
      if ({1'b0, r.cnt} >= mask) begin
        next_r.cnt = 8'h00;
        next_r.full = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign full_pulse = r.full;

endmodule : srr_fullstep_div

`default_nettype wire

//--- design/srr_pkg.sv
// Constants and types shared by the step-rate ramp generator
`default_nettype none

package srr_pkg;

  // ----------------------------------------------------------------
  // Clock and reference
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned REF_HZ    = 16_000_000;
  localparam int unsigned REF_GRAIN = 1_000_000;
  localparam logic [7:0]  REF_INC   = 8'(REF_HZ / REF_GRAIN);
  localparam logic [7:0]  REF_MOD   = 8'(CLK_HZ / REF_GRAIN);

  // ----------------------------------------------------------------
  // Velocity and acceleration scaling
  // ----------------------------------------------------------------
  localparam int          VEL_W         = 12;
  localparam logic [10:0] VEL_MAX       = 11'h7FF;
  localparam logic [10:0] ACC_MAX       = 11'h7FF;
  localparam logic [3:0]  PDIV_MAX      = 4'hD;
  localparam logic [3:0]  RDIV_MAX      = 4'hD;
  localparam logic [4:0]  VEL_SCALE_EXP = 5'h10;
  localparam logic [4:0]  ACC_BASE_EXP  = 5'h1D;
  localparam logic [4:0]  ACC_EXP_OFF   = ACC_BASE_EXP - VEL_SCALE_EXP;
  localparam int          ACC_LO_OFF    = 1;
  localparam int          ACC_HI_OFF    = 12;
  localparam int          ACC_HI_BITS   = 11;
  localparam int          RATE_ACC_W    = 31;

  // ----------------------------------------------------------------
  // Microstep resolution
  // ----------------------------------------------------------------
  localparam logic [3:0]  USTEP_RES_MAX     = 4'h8;
  localparam logic [3:0]  USTEP_RES_DEFAULT = 4'h8;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRR_IDLE,
    SRR_ROTATE,
    SRR_POSITION
  } srr_mode_t;

endpackage : srr_pkg

`default_nettype wire

//--- design/srr_ramp_gen.sv
// Step-rate ramp generator: velocity ramp, microstep and full-step pulses
`timescale 1ns/100ps
`default_nettype none

module srr_ramp_gen
  import srr_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Configuration
  input  wire logic [10:0]        vel_limit,
  input  wire logic [10:0]        accel,
  input  wire logic [3:0]         pulse_div,
  input  wire logic [3:0]         ramp_div,
  input  wire logic               ures_wr,
  input  wire logic [3:0]         ures_in,
  // Commands
  input  wire logic               move_to_position_cmd,
  input  wire logic signed [31:0] target_position,
  input  wire logic               rotate_left_cmd,
  input  wire logic               rotate_right_cmd,
  input  wire logic               stop_cmd,
  // Driver side
  output logic                    step_pulse,
  output logic                    step_dir,
  output logic                    full_step_pulse,
  // Status
  output logic signed [11:0]      actual_velocity,
  output logic signed [31:0]      actual_position,
  output logic                    motion_idle,
  output logic [3:0]              microstep_resolution_setting,
  output logic [10:0]             accel_in_use
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    srr_mode_t          mode;
    logic signed [11:0] vel;
    logic signed [11:0] tgt_vel;
    logic signed [31:0] pos;
    logic signed [31:0] tgt_pos;
    logic [31:0]        ramp_steps;
    logic [7:0]         ref_acc;
    logic               ref_tick;
    logic               step;
    logic               dir;
    logic [3:0]         ures;
    logic [10:0]        acc_eff;
  } srr_state_t;

  srr_state_t r;
  srr_state_t next_r;

  srr_rate_if step_if ();
  srr_rate_if acc_if ();

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] mag12(input logic signed [11:0] v);
    logic [11:0] a;
    a = v[11] ? 12'(-v) : 12'(v);
    mag12 = (a > {1'b0, VEL_MAX}) ? VEL_MAX : a[10:0];
  endfunction

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  function automatic logic [3:0] clamp4(input logic [3:0] v, input logic [3:0] lim);
    clamp4 = (v > lim) ? lim : v;
  endfunction

  function automatic logic signed [11:0] vel_of(input logic [10:0] m, input logic neg);
    logic signed [11:0] v;
    v      = 12'(signed'({1'b0, m}));
    vel_of = neg ? -v : v;
  endfunction

  // Lower bound rounds up to one; upper bound wins a conflict
  function automatic logic [10:0] limit_accel(input logic [10:0] a,
                                              input logic [3:0]  rd,
                                              input logic [3:0]  pd);
    logic signed [6:0] e;
    logic signed [6:0] elo;
    logic signed [6:0] ehi;
    logic [10:0]       lo;
    logic [10:0]       hi;
    e   = 7'(signed'({1'b0, rd})) - 7'(signed'({1'b0, pd}));
    elo = e - 7'(ACC_LO_OFF);
    ehi = e + 7'(ACC_HI_OFF);
    if (elo < 0) begin
      lo = 11'h001;
    end else if (elo >= 7'(ACC_HI_BITS)) begin
      lo = ACC_MAX;
    end else begin
      lo = 11'h001 << elo[3:0];
    end
    if (ehi < 0) begin
      hi = 11'h000;
    end else if (ehi >= 7'(ACC_HI_BITS)) begin
      hi = ACC_MAX;
    end else begin
      hi = (11'h001 << ehi[3:0]) - 11'h001;
    end
    limit_accel = a;
    if (limit_accel < lo) begin
      limit_accel = lo;
    end
    if (limit_accel > hi) begin
      limit_accel = hi;
    end
  endfunction

  // ----------------------------------------------------------------
  // Derived settings
  // ----------------------------------------------------------------
  logic [3:0]         pdiv_c;
  logic [3:0]         rdiv_c;
  logic [10:0]        vmax;
  logic [8:0]         ref_sum;
  logic signed [31:0] rem;
  logic [10:0]        vel_mag;
  logic [10:0]        tgt_mag;

  assign pdiv_c = clamp4(pulse_div, PDIV_MAX);
  assign rdiv_c = clamp4(ramp_div, RDIV_MAX);
  assign vmax   = (vel_limit > VEL_MAX) ? VEL_MAX : vel_limit;

  // ----------------------------------------------------------------
  // Rate generators
  // ----------------------------------------------------------------
  assign step_if.rate = mag12(r.vel);
  assign step_if.exp  = VEL_SCALE_EXP + 5'(pdiv_c);
  assign acc_if.rate  = r.acc_eff;
  assign acc_if.exp   = ACC_EXP_OFF + 5'(rdiv_c);

  srr_rate_gen #(
    .ACC_W (RATE_ACC_W)
  ) u_step_gen (
    .clk      (clk),
    .rst_n    (rst_n),
    .ref_tick (r.ref_tick),
    .rif      (step_if.gen)
  );

  srr_rate_gen #(
    .ACC_W (RATE_ACC_W)
  ) u_acc_gen (
    .clk      (clk),
    .rst_n    (rst_n),
    .ref_tick (r.ref_tick),
    .rif      (acc_if.gen)
  );

  srr_fullstep_div u_full_div (
    .clk         (clk),
    .rst_n       (rst_n),
    .ustep_pulse (r.step),
    .ures        (r.ures),
    .full_pulse  (full_step_pulse)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.step = 1'b0;

    // 16 MHz reference tick from the system clock
    // Tick spacing jitters between 6 and 7 clocks
    ref_sum = {1'b0, r.ref_acc} + {1'b0, REF_INC};
    if (ref_sum >= {1'b0, REF_MOD}) begin
      next_r.ref_acc  = 8'(ref_sum - {1'b0, REF_MOD});
      next_r.ref_tick = 1'b1;
    end else begin
      next_r.ref_acc  = 8'(ref_sum);
      next_r.ref_tick = 1'b0;
    end

    // Microstep resolution setting
    if (ures_wr) begin
      next_r.ures = clamp4(ures_in, USTEP_RES_MAX);
    end

    // Commands, stop first
    if (stop_cmd) begin
      next_r.mode = SRR_IDLE;
    end else if (rotate_left_cmd) begin
      next_r.mode    = SRR_ROTATE;
      next_r.tgt_vel = vel_of(vmax, 1'b1);
    end else if (rotate_right_cmd) begin
      next_r.mode    = SRR_ROTATE;
      next_r.tgt_vel = vel_of(vmax, 1'b0);
    end else if (move_to_position_cmd) begin
      next_r.mode    = SRR_POSITION;
      next_r.tgt_pos = target_position;
    end

    // Target velocity by mode
    rem     = next_r.tgt_pos - r.pos;
    vel_mag = mag12(r.vel);
    case (next_r.mode)
      SRR_IDLE: begin
        next_r.tgt_vel = 12'sh000;
      end
      SRR_ROTATE: begin
        next_r.tgt_vel = next_r.tgt_vel;
      end
      SRR_POSITION: begin
        if (rem == 32'sh0000_0000) begin
          next_r.tgt_vel = 12'sh000;
          if (r.vel == 12'sh000) begin
            next_r.mode = SRR_IDLE;
          end
        end else if (r.vel != 12'sh000 && mag32(rem) <= r.ramp_steps) begin
          next_r.tgt_vel = 12'sh000;
        end else if (rem[31]) begin
          next_r.tgt_vel = vel_of(vmax, 1'b1);
        end else begin
          next_r.tgt_vel = vel_of(vmax, 1'b0);
        end
      end
      default: begin
        next_r.mode = SRR_IDLE;
      end
    endcase

    // Acceleration limits apply to positioning only
    if (next_r.mode == SRR_POSITION) begin
      next_r.acc_eff = limit_accel(accel, rdiv_c, pdiv_c);
    end else begin
      next_r.acc_eff = accel;
    end

    // Ramp one velocity unit toward target per acceleration pulse
    if (acc_if.pulse) begin
      if (r.vel < r.tgt_vel) begin
        next_r.vel = r.vel + 12'sh001;
      end else if (r.vel > r.tgt_vel) begin
        next_r.vel = r.vel - 12'sh001;
      end
    end

    // Microstep issue and position tracking
    tgt_mag = mag12(r.tgt_vel);
    if (step_if.pulse) begin
      next_r.step = 1'b1;
      next_r.dir  = r.vel[11];
      next_r.pos  = r.vel[11] ? r.pos - 32'sh0000_0001 : r.pos + 32'sh0000_0001;
      if (r.mode == SRR_POSITION && r.tgt_vel != 12'sh000 && vel_mag < tgt_mag) begin
        next_r.ramp_steps = r.ramp_steps + 32'h0000_0001;
      end
    end
    // Braking distance is the step count of the latest run-up
    if (move_to_position_cmd || r.vel == 12'sh000) begin
      next_r.ramp_steps = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r      <= '0;
      r.mode <= SRR_IDLE;
      r.ures <= USTEP_RES_DEFAULT;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign step_pulse                   = r.step;
  assign step_dir                     = r.dir;
  assign actual_velocity              = r.vel;
  assign actual_position              = r.pos;
  assign motion_idle                  = (r.mode == SRR_IDLE) && (r.vel == 12'sh000);
  assign microstep_resolution_setting = r.ures;
  assign accel_in_use                 = r.acc_eff;

endmodule : srr_ramp_gen

`default_nettype wire

//--- design/srr_rate_gen.sv
// Phase accumulator: pulse rate = ref rate * rate / 2^exp
`timescale 1ns/100ps
`default_nettype none

module srr_rate_gen
  import srr_pkg::*;
#(
  parameter int ACC_W = RATE_ACC_W
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Reference tick
  input  wire logic ref_tick,
  // Rate request
  srr_rate_if.gen   rif
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             pulse;
  } srr_gen_state_t;

  srr_gen_state_t r;
  srr_gen_state_t next_r;
  logic [ACC_W:0] sum;
  logic [ACC_W:0] lim;

  always_comb begin
    next_r = r;
    next_r.pulse = 1'b0;
    sum = {1'b0, r.acc} + (ACC_W + 1)'(rif.rate);
    lim = (ACC_W + 1)'(1) << rif.exp;
    if (ref_tick) begin
      if (sum >= lim) begin
        next_r.acc = ACC_W'(sum - lim);
        next_r.pulse = 1'b1;
      end else begin
        next_r.acc = ACC_W'(sum);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rif.pulse = r.pulse;

endmodule : srr_rate_gen

`default_nettype wire

//--- design/srr_rate_if.sv
// Rate request and pulse carrier between the ramp core and a rate generator
`timescale 1ns/100ps
`default_nettype none

interface srr_rate_if;
  logic [10:0] rate;
  logic [4:0]  exp;
  logic        pulse;

  modport src (output rate, output exp, input pulse);
  modport gen (input rate, input exp, output pulse);
endinterface : srr_rate_if

`default_nettype wire

//--- verif/srr_drv_model.sv
// Motor driver model: counts microsteps and full steps
`timescale 1ns/100ps
`default_nettype none

module srr_drv_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Step inputs
  input  wire logic step_pulse,
  input  wire logic step_dir,
  input  wire logic full_step_pulse,
  // Counts
  output var int    pos,
  output var int    n_steps,
  output var int    n_full
);
  always @(posedge clk) begin
    if (!rst_n) begin
      pos <= 0;
      n_steps <= 0;
      n_full <= 0;
    end else begin
      if (step_pulse) begin
        pos <= step_dir ? pos - 1 : pos + 1;
        n_steps <= n_steps + 1;
      end
      if (full_step_pulse) n_full <= n_full + 1;
    end
  end
endmodule // srr_drv_model

`default_nettype wire

//--- verif/srr_ramp_gen_bench.sv
// Self-checking bench for the step-rate ramp generator
`timescale 1ns/100ps
`default_nettype none

module srr_ramp_gen_bench;
  logic               clk, rst_n, ures_wr, mv, rl, rr, st, step_pulse, step_dir, full_step_pulse, motion_idle;
  logic [10:0]        vel_limit, accel, accel_in_use;
  logic [3:0]         pulse_div, ramp_div, ures_in, ures;
  logic signed [31:0] tgt, actual_position;
  logic signed [11:0] actual_velocity;
  int                 n_errors, n_checks, seed, i, c, s, rd, pd, a, p0, pos, n_steps, n_full;
  logic [3:0]         rdv [4] = '{4'hD, 4'h0, 4'h5, 4'h8};
  logic [3:0]         pdv [4] = '{4'h0, 4'hD, 4'h5, 4'h3};

  srr_ramp_gen DUT (.clk(clk), .rst_n(rst_n), .vel_limit(vel_limit), .accel(accel), .pulse_div(pulse_div),
    .ramp_div(ramp_div), .ures_wr(ures_wr), .ures_in(ures_in), .move_to_position_cmd(mv),
    .target_position(tgt), .rotate_left_cmd(rl), .rotate_right_cmd(rr), .stop_cmd(st),
    .step_pulse(step_pulse), .step_dir(step_dir), .full_step_pulse(full_step_pulse),
    .actual_velocity(actual_velocity), .actual_position(actual_position), .motion_idle(motion_idle),
    .microstep_resolution_setting(ures), .accel_in_use(accel_in_use));
  srr_drv_model u_drv (.clk(clk), .rst_n(rst_n), .step_pulse(step_pulse), .step_dir(step_dir),
    .full_step_pulse(full_step_pulse), .pos(pos), .n_steps(n_steps), .n_full(n_full));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmd(input int k);
    @(posedge clk);
    case (k)
      0: st <= 1'b1;
      1: rl <= 1'b1;
      2: rr <= 1'b1;
      3: mv <= 1'b1;
      default: ures_wr <= 1'b1;
    endcase
    @(posedge clk);
    {st, rl, rr, mv, ures_wr} <= 5'h00;
    #1;
  endtask
  task automatic chk_val(input logic signed [31:0] got, input logic signed [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp, input int tol);
    n_checks++;
    if (got < exp - tol || got > exp + tol) begin
      n_errors++;
      $display("wrong value at %0t: got %0d expected about %0d", $time, got, exp);
    end
  endtask
  task automatic wait_vel(input logic signed [11:0] v);
    c = 0;
    while (actual_velocity !== v && c < 40000) begin
      tick(1);
      c++;
    end
  endtask
  task automatic wait_idle();
    c = 0;
    while (motion_idle !== 1'b1 && c < 60000) begin
      tick(1);
      c++;
    end
  endtask
  task automatic count_steps(input int n);
    s = 0;
    repeat (n) begin
      tick(1);
      if (step_pulse === 1'b1) s++;
    end
  endtask
  function automatic int exp_steps(int v, int p, int n);
    return int'((longint'(v) * n * 16) / (longint'(100) << (p + 16)));
  endfunction
  function automatic int ramp_cyc(int v, int aa, int r);
    return int'(((longint'(v) * 100) << (r + 13)) / (16 * aa));
  endfunction
  function automatic int exp_acc(int aa, int r, int p);
    int e, lo, hi;
    e = r - p;
    lo = (e < 1) ? 1 : (1 << (e - 1));
    hi = (e < -12) ? 0 : ((e >= -1) ? 2047 : (1 << (e + 12)) - 1);
    if (aa < lo) aa = lo;
    if (aa > hi) aa = hi;
    return aa;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {rst_n, ures_wr, mv, rl, rr, st} = 6'h00;
    {vel_limit, accel, pulse_div, ramp_div, ures_in, tgt} = {11'h0C8, 11'h7FF, 12'h000, 32'h0};
    seed = 32'h78F9;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk_val(ures, 8);
    chk_val(actual_velocity, 0);
    for (i = 0; i < 13; i++) begin
      @(posedge clk) ures_in <= (i == 12) ? 4'h2 : ((i < 10) ? 4'(i) : 4'($random(seed)));
      cmd(4);
      chk_val(ures, (ures_in > 4'h8) ? 8 : ures_in);
    end
    $display("test resolution done");
    cmd(2);
    wait_vel(12'sd200);
    chk_val(actual_velocity, 200);
    chk_near(c, ramp_cyc(200, 2047, 0), ramp_cyc(200, 2047, 0) / 20 + 4);
    count_steps(16384);
    chk_near(s, exp_steps(200, 0, 16384), 1);
    @(posedge clk) pulse_div <= 4'h1;
    count_steps(16384);
    chk_near(s, exp_steps(200, 1, 16384), 1);
    cmd(1);
    wait_vel(-12'sd200);
    chk_val(actual_velocity, -200);
    cmd(0);
    wait_idle();
    chk_val(actual_velocity, 0);
    chk_val(actual_position, pos);
    chk_val(n_full, n_steps >>> 2);
    $display("test rotate done");
    for (i = 0; i < 6; i++) begin
      rd = (i < 4) ? rdv[i] : $unsigned($random(seed)) % 14;
      pd = (i < 4) ? pdv[i] : $unsigned($random(seed)) % 14;
      a = $unsigned($random(seed)) % 2048;
      @(posedge clk) ramp_div <= 4'(rd);
      pulse_div <= 4'(pd);
      accel <= 11'(a);
      tgt <= actual_position + 1000;
      cmd(3);
      tick(2);
      chk_val(accel_in_use, exp_acc(a, rd, pd));
      cmd(2);
      tick(2);
      chk_val(accel_in_use, a);
      @(posedge clk) ramp_div <= 4'h0;
      accel <= 11'h7FF;
      cmd(0);
      wait_idle();
      chk_val(motion_idle, 1'b1);
    end
    $display("test limits done");
    p0 = actual_position;
    @(posedge clk) pulse_div <= 4'h0;
    ramp_div <= 4'h0;
    accel <= 11'h7FF;
    vel_limit <= 11'h096;
    tgt <= p0 + 4;
    cmd(3);
    wait_idle();
    chk_val(actual_position, p0 + 4);
    chk_val(pos, p0 + 4);
    $display("test move done");
    give_verdict();
  end

  initial begin
    #1000000;
    n_errors++;
    $display("wrong value at %0t: timeout", $time);
    give_verdict();
  end
endmodule // srr_ramp_gen_bench

`default_nettype wire

//--- verif/srr_ramp_gen_chk.sv
// Port-level assertions for the step-rate ramp generator
`timescale 1ns/100ps
`default_nettype none

module srr_ramp_gen_chk (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Resolution load
  input wire logic               ures_wr,
  input wire logic [3:0]         ures_in,
  // Driver side
  input wire logic               step_pulse,
  input wire logic               step_dir,
  input wire logic               full_step_pulse,
  // Status
  input wire logic signed [11:0] actual_velocity,
  input wire logic signed [31:0] actual_position,
  input wire logic               motion_idle,
  input wire logic [3:0]         microstep_resolution_setting
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_step; step_pulse; endsequence
  sequence s_gap; !step_pulse [*5]; endsequence

  AST_RESET_STATE: assert property ($rose(rst_n) |-> microstep_resolution_setting == 4'h8 && motion_idle)
    else $error("state after reset is wrong");
  AST_RES_LOAD: assert property (ures_wr && ures_in <= 4'h8 |=> microstep_resolution_setting == $past(ures_in))
    else $error("resolution not loaded");
  AST_RES_CLAMP: assert property (ures_wr && ures_in > 4'h8 |=> microstep_resolution_setting == 4'h8)
    else $error("resolution not clamped");
  AST_STEP_GAP: assert property (s_step |=> s_gap)
    else $error("steps too close");
  AST_POS_DIR: assert property ($past(rst_n) |->
    actual_position - $past(actual_position) == (step_pulse ? (step_dir ? -32'sd1 : 32'sd1) : 32'sd0))
    else $error("position does not follow steps");
  AST_VEL_RANGE: assert property (actual_velocity >= -12'sd2047 && actual_velocity <= 12'sd2047)
    else $error("velocity out of range");
  AST_VEL_STEP: assert property ($past(rst_n) && actual_velocity != $past(actual_velocity) |->
    actual_velocity - $past(actual_velocity) == 12'sd1 || actual_velocity - $past(actual_velocity) == -12'sd1)
    else $error("velocity jumped");
  AST_FULL_AFTER_STEP: assert property (full_step_pulse |-> $past(step_pulse))
    else $error("full step without microstep");
endmodule // srr_ramp_gen_chk

bind srr_ramp_gen srr_ramp_gen_chk u_chk (.clk(clk), .rst_n(rst_n), .ures_wr(ures_wr), .ures_in(ures_in),
  .step_pulse(step_pulse), .step_dir(step_dir), .full_step_pulse(full_step_pulse),
  .actual_velocity(actual_velocity), .actual_position(actual_position), .motion_idle(motion_idle),
  .microstep_resolution_setting(microstep_resolution_setting));

`default_nettype wire
